// ===== inc/fbr_pkg.sv
// package: constants and types for the flash burst read port
package fbr_pkg;
	localparam int ADDR_W      = 19;
	localparam int DATA_W      = 16;
	localparam int BURST_W     = 5;
	localparam int BURST_LEN   = 32;
	localparam logic [BURST_W-1:0] BURST_LAST = 5'h1f;
	localparam int FIFO_DEPTH  = 16;
	localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam int MEM_WORDS   = 256;
	localparam int MEM_AW      = 8;

	typedef enum logic [1:0]
	{
		FBR_IDLE  = 2'b00,
		FBR_FETCH = 2'b01,
		FBR_WAIT  = 2'b11
	} fbr_fill_t;
endpackage

// ===== inc/fbr_fifo_if.sv
// interface: valid/ready word stream between fifo and its neighbours
`timescale 1ns/100ps
interface fbr_fifo_if #(parameter int W = 16);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready,
		input in_ready, out_valid, out_data);
endinterface

// ===== core/fbr_fifo.sv
// dual-clock fifo with gray pointers, registered read data
`timescale 1ns/100ps
module fbr_fifo
	import fbr_pkg::*;
#(
	parameter int W = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic wr_clk,
	input  wire logic rd_clk,
	input  wire logic rst,
	fbr_fifo_if.fifo  f
);
	localparam int AW = $clog2(DEPTH);

	function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	logic [W-1:0]  mem [DEPTH];
	logic [AW:0]   wp_q, rp_q, wg_q, rg_q;
	logic [AW:0]   wg_s1_q, wg_s2_q, rg_s1_q, rg_s2_q;
	logic          ov_q;
	logic [W-1:0]  od_q;
	logic          full, empty, pop;

	// ==========================================================
	// write side
	assign full = (wg_q == {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
	assign f.in_ready = ~full;
	always_ff @(posedge wr_clk or posedge rst)
		if (rst)
		begin
			wp_q <= '0;
			wg_q <= '0;
			rg_s1_q <= '0;
			rg_s2_q <= '0;
		end
		else
		begin
			rg_s1_q <= rg_q;
			rg_s2_q <= rg_s1_q;
			if (f.in_valid && !full)
			begin
				wp_q <= wp_q + 1'b1;
				wg_q <= bin2gray(wp_q + 1'b1);
			end
		end
	always_ff @(posedge wr_clk)
		if (f.in_valid && !full)
			mem[wp_q[AW-1:0]] <= f.in_data;

	// ==========================================================
	// read side: one-word output register
	assign empty = (rg_q == wg_s2_q);
	assign pop = !empty && (!ov_q || f.out_ready);
	assign f.out_valid = ov_q;
	assign f.out_data = od_q;
	always_ff @(posedge rd_clk or posedge rst)
		if (rst)
		begin
			rp_q <= '0;
			rg_q <= '0;
			wg_s1_q <= '0;
			wg_s2_q <= '0;
			ov_q <= 1'b0;
			od_q <= '0;
		end
		else
		begin
			wg_s1_q <= wg_q;
			wg_s2_q <= wg_s1_q;
			if (pop)
			begin
				od_q <= mem[rp_q[AW-1:0]];
				ov_q <= 1'b1;
				rp_q <= rp_q + 1'b1;
				rg_q <= bin2gray(rp_q + 1'b1);
			end
			else if (f.out_ready)
				ov_q <= 1'b0;
		end
endmodule

// ===== core/fbr_mem.sv
// small word array with registered read data, loadable from the fill port
`timescale 1ns/100ps
module fbr_mem
	import fbr_pkg::*;
#(
	parameter int W = DATA_W,
	parameter int AW = MEM_AW
)
(
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	logic [W-1:0] arr [2**AW];
	always_ff @(posedge clk)
	begin
		if (we)
			arr[waddr] <= wdata;
		rdata <= arr[raddr];
	end
endmodule

// ===== core/fbr_port.sv
// flash burst read port: link-side burst counter fed by a word fifo
// ==========================================================
// What this block does
// R1 - low load strobe at rising link clock captures address as burst start
// R2 - load strobe high: address ignored, start address kept
// R3 - advance strobe low at rising edge steps address, shows next word
// R4 - advance strobe high: address held, data outputs unchanged; dq_o still takes a word owed by a load or step
// R5 - last-word flag low while word at start plus 31 is shown; flag tracks cur_addr, a cycle or more ahead of dq_o
// R6 - after final word the next advance wraps to the start word
// R7 - chip, output and write enables are asynchronous, synchronised first
// R8 - all burst activity runs on rising edge of the link clock
// R9 - 19-bit word address, 16-bit data bus, low 5 bits wrap
`timescale 1ns/100ps
module fbr_port
	import fbr_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              clk_burst,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              burst_addr_load_n,
	input  wire logic              burst_step_n,
	input  wire logic              chip_en_n,
	input  wire logic              out_en_n,
	input  wire logic              write_en_n,
	input  wire logic              fill_we,
	input  wire logic [MEM_AW-1:0] fill_addr,
	input  wire logic [DATA_W-1:0] fill_data,
	output logic      [DATA_W-1:0] dq_o,
	output logic                   dq_oe,
	output logic                   burst_last_word_n,
	output logic      [ADDR_W-1:0] cur_addr
);
	// ==========================================================
	// link-domain state
	localparam int OWE_W = BURST_W + 1;

	typedef struct packed {
		logic [ADDR_W-1:0] start;
		logic [BURST_W-1:0] cnt;
		logic [DATA_W-1:0] dout;
		logic              last_n;
		logic              oe;
		logic              ce_s1, ce_s2, oe_s1, oe_s2, we_s1, we_s2;
		logic              req_t;
		logic [ADDR_W-1:0] req_addr;
		logic [OWE_W-1:0]  owe;
	} fbr_lnk_t;

	// system-domain state
	typedef struct packed {
		fbr_fill_t         st;
		logic [ADDR_W-1:0] rd_addr;
		logic              t_s1, t_s2, t_s3;
		logic [ADDR_W-1:0] pend;
		logic              have;
		logic              gen;
	} fbr_sys_t;

	fbr_lnk_t l_q, l_d;
	fbr_sys_t s_q, s_d;
	logic [DATA_W-1:0] mem_rd;
	logic              take, adv, stale, use_w;

	// each fifo word carries the generation of the burst it was fetched for
	fbr_fifo_if #(.W(DATA_W+1)) fif ();

	function automatic logic [ADDR_W-1:0] word_at(
		input logic [ADDR_W-1:0] base, input logic [BURST_W-1:0] c);
		return {base[ADDR_W-1:BURST_W], c};
	endfunction

	// ==========================================================
	// link side
	assign take = l_q.ce_s2 & ~burst_addr_load_n;                  // [R1]
	assign adv = l_q.ce_s2 & burst_addr_load_n & ~burst_step_n;    // [R2] [R3]
	assign stale = fif.out_data[DATA_W] != l_q.req_t;
	// a word is shown only while a load or step still owes one
	assign use_w = fif.out_valid & ~stale & (l_q.owe != '0) & ~take;
	// words of an abandoned burst are dropped unseen
	assign fif.out_ready = fif.out_valid & stale | use_w;

	always_comb
	begin
		l_d = l_q;
		l_d.ce_s1 = ~chip_en_n;                                    // [R7]
		l_d.ce_s2 = l_q.ce_s1;
		l_d.oe_s1 = ~out_en_n;
		l_d.oe_s2 = l_q.oe_s1;
		l_d.we_s1 = ~write_en_n;
		l_d.we_s2 = l_q.we_s1;
		l_d.oe = l_q.ce_s2 & l_q.oe_s2 & ~l_q.we_s2;
		if (take)
		begin
			l_d.start = addr;                                      // [R9]
			l_d.cnt = addr[BURST_W-1:0];
			l_d.req_t = ~l_q.req_t;
			l_d.req_addr = addr;
			l_d.owe = OWE_W'(1);
		end
		else
		begin
			// low bits wrap by themselves back to the start word
			if (adv)
				l_d.cnt = l_q.cnt + 5'h01;                         // [R6]
			l_d.owe = l_q.owe + OWE_W'(adv) - OWE_W'(use_w);
		end
		if (use_w)                                                 // [R4]
			l_d.dout = fif.out_data[DATA_W-1:0];
		l_d.last_n = ~(l_d.cnt == l_d.start[BURST_W-1:0] + BURST_LAST); // [R5]
	end

	always_ff @(posedge clk_burst or posedge rst)                  // [R8]
		if (rst)
		begin
			l_q <= '0;
			l_q.start <= ADDR_RST;
			l_q.dout <= DATA_RST;
			l_q.last_n <= 1'b1;
		end
		else
			l_q <= l_d;

	assign dq_o = l_q.dout;
	assign dq_oe = l_q.oe;
	assign burst_last_word_n = l_q.last_n;
	assign cur_addr = word_at(l_q.start, l_q.cnt);

	// ==========================================================
	// system side: prefetch the 32 words of the burst into the fifo
	fbr_mem #(.W(DATA_W), .AW(MEM_AW)) u_mem (
		.clk   (clk_sys),
		.we    (fill_we),
		.waddr (fill_addr),
		.wdata (fill_data),
		.raddr (s_q.rd_addr[MEM_AW-1:0]),
		.rdata (mem_rd)
	);

	fbr_fifo #(.W(DATA_W+1), .DEPTH(FIFO_DEPTH)) u_fifo (
		.wr_clk (clk_sys),
		.rd_clk (clk_burst),
		.rst    (rst),
		.f      (fif)
	);

	assign fif.in_valid = (s_q.st == FBR_WAIT) && s_q.have;
	assign fif.in_data = {s_q.gen, mem_rd};

	always_comb
	begin
		s_d = s_q;
		s_d.t_s1 = l_q.req_t;
		s_d.t_s2 = s_q.t_s1;
		s_d.t_s3 = s_q.t_s2;
		case (s_q.st)
			FBR_IDLE:
				if (s_q.t_s2 != s_q.t_s3)
				begin
					// address is stable: it was captured on the same link edge as the toggle
					s_d.rd_addr = l_q.req_addr;
					s_d.pend = l_q.req_addr;
					s_d.gen = s_q.t_s2;
					s_d.st = FBR_FETCH;
				end
			FBR_FETCH:
			begin
				s_d.have = 1'b1;
				s_d.st = FBR_WAIT;
			end
			FBR_WAIT:
				if (s_q.t_s2 != s_q.t_s3)
				begin
					s_d.rd_addr = l_q.req_addr;
					s_d.pend = l_q.req_addr;
					s_d.gen = s_q.t_s2;
					s_d.have = 1'b0;
					s_d.st = FBR_FETCH;
				end
				else if (fif.in_ready)
				begin
					s_d.rd_addr = word_at(s_q.pend,
						s_q.rd_addr[BURST_W-1:0] + 5'h01);
					s_d.have = 1'b0;
					s_d.st = FBR_FETCH;
				end
			default:
				s_d.st = FBR_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			s_q <= '0;
			s_q.st <= FBR_IDLE;
		end
		else
			s_q <= s_d;
endmodule

// ===== verification/fbr_port_properties.sv
// checker: burst port properties, bound to every fbr_port instance
`timescale 1ns/100ps
module fbr_port_properties
	import fbr_pkg::*;
(
	input wire logic rst,
	input wire logic clk_burst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic burst_addr_load_n,
	input wire logic burst_step_n,
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic [DATA_W-1:0] dq_o,
	input wire logic dq_oe,
	input wire logic burst_last_word_n,
	input wire logic [ADDR_W-1:0] cur_addr
);
	logic [2:0] ce_q;
	logic [3:0] oe_q;
	logic [4:0] s_q;
	logic [4:0] idle_q;
	// enables pass a sync inside, so only settled levels count
	wire en = ~|ce_q & ~chip_en_n;
	wire ld = en & ~burst_addr_load_n;
	wire st = en & burst_addr_load_n & ~burst_step_n;
	wire idle = en & burst_addr_load_n & burst_step_n;
	wire [ADDR_W-1:0] nxt = {cur_addr[18:5], cur_addr[4:0] + 5'h01};
	always_ff @(posedge clk_burst or posedge rst)
		if (rst)
			{ce_q, oe_q, s_q, idle_q} <= {7'h7f, 10'h000};
		else
		begin
			ce_q <= {ce_q[1:0], chip_en_n};
			oe_q <= {oe_q[2:0], out_en_n};
			if (ld)
				s_q <= addr[4:0];
			if (!idle)
				idle_q <= 5'h00;
			else if (idle_q != 5'h1f)
				idle_q <= idle_q + 5'h01;
		end
	// ====
	// properties
	default clocking @(posedge clk_burst); endclocking
	default disable iff (rst);
	load_take_a: assert property (ld |=> cur_addr == $past(addr))
		else $error("start address not loaded");
	step_wrap_a: assert property (st |=> cur_addr == $past(nxt))
		else $error("advance went wrong");
	addr_hold_a: assert property (idle |=> $stable(cur_addr))
		else $error("address moved while idle");
	high_bits_a: assert property (en && burst_addr_load_n |=>
		$stable(cur_addr[18:5])) else $error("left the 32-word block");
	last_flag_a: assert property (burst_last_word_n ==
		(cur_addr[4:0] != s_q - 5'h01)) else $error("last flag wrong");
	data_hold_a: assert property (idle_q == 5'h1f |=> $stable(dq_o))
		else $error("data changed while idle");
	oe_off_a: assert property (&oe_q && out_en_n |-> !dq_oe)
		else $error("bus driven with output off");
	chip_off_a: assert property (&ce_q && chip_en_n |=>
		$stable(cur_addr)) else $error("moved while chip off");
	cover property (ld ##1 st);
	cover property (!burst_last_word_n ##[1:8] st);
	cover property (idle_q == 5'h1f && dq_oe);
endmodule
bind fbr_port fbr_port_properties i_props (.*);

// ===== verification/fbr_host.sv
// host model: drives load and advance strobes on the link clock
`timescale 1ns/100ps
module fbr_host
	import fbr_pkg::*;
(
	input wire logic clk_burst,
	input wire logic do_load,
	input wire logic do_step,
	input wire logic [ADDR_W-1:0] start,
	output logic [ADDR_W-1:0] addr = '0,
	output logic burst_addr_load_n = 1'b1,
	output logic burst_step_n = 1'b1
);
	always @(posedge clk_burst)
	begin
		burst_addr_load_n <= !do_load;
		burst_step_n <= !do_step;
		// address invalid outside a load: inverted each cycle, so a stale copy every other cycle
		addr <= do_load ? start : ~addr;
	end
endmodule

// ===== verification/fbr_port_tb.sv
// testbench: burst load, advance, wrap and enable scenarios
`timescale 1ns/100ps
module fbr_port_tb
	import fbr_pkg::*;
;
	localparam logic [ADDR_W-1:0] BASE = 19'h45a3d;
	logic clk_sys = 1'b0, clk_burst = 1'b0, rst = 1'b1;
	logic chip_en_n = 1'b1, out_en_n = 1'b1, write_en_n = 1'b1;
	logic fill_we = 1'b0, do_load = 1'b0, do_step = 1'b0;
	logic burst_addr_load_n, burst_step_n, dq_oe, burst_last_word_n;
	logic [MEM_AW-1:0] fill_addr = '0;
	wire [DATA_W-1:0] fill_data = {~fill_addr, fill_addr};
	logic [DATA_W-1:0] dq_o;
	logic [ADDR_W-1:0] start = '0, addr, cur_addr;
	int mismatches = 0, comparisons = 0, cycles = 0;
	fbr_port i_dut (.*);
	fbr_host i_host (.*);
	initial forever #2 clk_sys = ~clk_sys;
	initial #1.3 forever #3 clk_burst = ~clk_burst;
	// ====
	// checks
	task automatic chk(input string n, input logic [ADDR_W-1:0] e, s);
		comparisons++;
		if (e !== s)
			$display("mismatch %s expected %h seen %h", n, e, s);
		mismatches += int'(e !== s);
	endtask
	task automatic summarize;
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_sys)
		if (++cycles == 3000)
		begin
			mismatches++;
			summarize;
		end
	task automatic t_en(input logic v, w);
		@(posedge clk_sys);
		chip_en_n <= v;
		out_en_n <= v;
		write_en_n <= w;
		repeat (8) @(posedge clk_burst);
	endtask
	// optional load, n advance cycles, then idle so the data settles
	task automatic t_burst(input logic ld, input logic [ADDR_W-1:0] a,
		input int n, input logic [ADDR_W-1:0] e, input logic l, oe);
		@(posedge clk_burst);
		start <= a;
		do_load <= ld;
		do_step <= (n > 0);
		@(posedge clk_burst);
		do_load <= 1'b0;
		repeat (n - 1) @(posedge clk_burst);
		do_step <= 1'b0;
		repeat (40) @(posedge clk_burst);
		#1;
		chk("cur_addr", e, cur_addr);
		chk("last_n", l, burst_last_word_n);
		chk("dq_oe", oe, dq_oe);
		chk("dq_o", {3'h0, ~e[7:0], e[7:0]}, dq_o);
	endtask
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		fill_we <= 1'b1;
		repeat (MEM_WORDS) @(posedge clk_sys) fill_addr <= fill_addr + 8'h01;
		fill_we <= 1'b0;
		t_en(1'b0, 1'b1);
		t_burst(1'b1, BASE, 0, BASE, 1'b1, 1'b1);
		t_burst(1'b0, BASE, 31, BASE - 19'h1, 1'b0, 1'b1);
		t_burst(1'b0, BASE, 1, BASE, 1'b1, 1'b1);
		t_en(1'b1, 1'b1);
		t_burst(1'b0, BASE, 5, BASE, 1'b1, 1'b0);
		t_en(1'b0, 1'b1);
		t_burst(1'b1, 19'h7ffe0, 5, 19'h7ffe4, 1'b1, 1'b1);
		t_en(1'b0, 1'b0);
		t_burst(1'b0, BASE, 0, 19'h7ffe4, 1'b1, 1'b0);
		summarize;
	end
endmodule
